// *** lhi_bus_if.sv ***
// Pin-level link between host controller and LCD driver
`timescale 1ns/1ps
interface lhi_bus_if;
  logic resetN;
  logic standbyN;
  logic parallelSel;
  logic busStyleSel;
  logic clockSourceStrap;
  logic chipSelectLowActiveN;
  logic chipSelectHighActive;
  logic registerSelect;
  logic readStrobeN;
  logic writeStrobeN;
  logic [7:0] hostDataOut;
  logic [7:0] hostDataOe;
  logic [7:0] devDataOut;
  logic [7:0] devDataOe;
  logic [7:0] dataBus;
  logic hostClkOut;
  logic hostClkOe;
  logic devClkOut;
  logic devClkOe;
  logic oscillatorMonitorPin;
  // Resolved data lines, pulled high when nobody drives
  assign dataBus = (hostDataOe & hostDataOut) | (devDataOe & devDataOut) | ~(hostDataOe | devDataOe);
  // Resolved clock pin, pulled low when nobody drives
  assign oscillatorMonitorPin = (hostClkOe & hostClkOut) | (devClkOe & devClkOut);
  // Driver side
  modport dev (
    input resetN, standbyN, parallelSel, busStyleSel, clockSourceStrap,
    input chipSelectLowActiveN, chipSelectHighActive, registerSelect,
    input readStrobeN, writeStrobeN, dataBus, oscillatorMonitorPin,
    output devDataOut, devDataOe, devClkOut, devClkOe
  );
  // Controller side
  modport host (
    output resetN, standbyN, parallelSel, busStyleSel, clockSourceStrap,
    output chipSelectLowActiveN, chipSelectHighActive, registerSelect,
    output readStrobeN, writeStrobeN, hostDataOut, hostDataOe, hostClkOut, hostClkOe,
    input dataBus, oscillatorMonitorPin
  );
endinterface : lhi_bus_if

// *** lhi_device.sv ***
// LCD driver end: parallel and serial host port, clock source and standby
`timescale 1ns/1ps
`include "lhi_params.svh"
// What this block does
// - Select low means number, high means data
// - Strobe mode drives read data while strobe low
// - Strobe mode captures write at strobe rise
// - Enable mode: enable pin, direction select pin
// - Transfer only with both chip selects active
// - Reset pin low resets the device
// - Interface strap high parallel, low serial
// - Bus-style strap high enable, low strobe
// - Serial mode leaves six low lines undriven
// - Line six serial clock, seven serial data
// - Serial accepted only with chip selects active
// - Bits MSB first, sampled on rising clock
// - Byte delivered on eighth rising clock edge
// - Select level at eighth edge types byte
// - Clock strap high oscillator, low external
// - Oscillator selected: clock pin monitors it
// - Standby pin low enters standby
// - Serial mode is write only
module lhi_device #(
  parameter int OSC_HALF = `LHI_OSC_HALF_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  lhi_bus_if.dev bus,
  input wire logic [7:0] readData,
  output logic writeStrobe,
  output logic writeIsData,
  output logic [7:0] writeByte,
  output logic readStrobe,
  output logic deviceInReset,
  output logic deviceStandby,
  output logic displayClock
);
  // Registered state and its next value
  lhi_pkg::lhi_dev_t s;
  lhi_pkg::lhi_dev_t next_s;
  // Pins after two flip-flops
  logic [`LHI_SV_WIDTH-1:0] pinRaw;
  logic [`LHI_SV_WIDTH-1:0] pin;
  // Decoded synchronised pins
  logic [7:0] dBus;
  logic rstN;
  logic stbN;
  logic parMode;
  logic enStyle;
  logic oscSel;
  logic csOn;
  logic rsel;
  logic rdN;
  logic wrN;
  logic clkPin;
  // Read drive request this cycle
  logic drive;

  // ***********************************
  // Pin synchronisation
  // ***********************************
  // Every pin passes the same two stages, so a strobe edge and the data
  // or select that it qualifies reach the logic in the same cycle;
  // separate synchronisers per pin could split them by one cycle
  assign pinRaw = {bus.resetN, bus.standbyN, bus.parallelSel, bus.busStyleSel,
                   bus.clockSourceStrap, bus.chipSelectLowActiveN, bus.chipSelectHighActive,
                   bus.registerSelect, bus.readStrobeN, bus.writeStrobeN,
                   bus.oscillatorMonitorPin, bus.dataBus};

  lhi_sync #(.WIDTH(`LHI_SV_WIDTH)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .async(pinRaw),
    .synced(pin)
  );

  // Field split of the synchronised vector
  assign dBus = pin[`LHI_SV_DATA +: 8];
  assign clkPin = pin[`LHI_SV_CLKPIN];
  assign wrN = pin[`LHI_SV_WRN];
  assign rdN = pin[`LHI_SV_RDN];
  assign rsel = pin[`LHI_SV_RSEL];
  // Both selects must be active at once; the host may tie either one
  assign csOn = ~pin[`LHI_SV_CSLN] & pin[`LHI_SV_CSH];
  assign oscSel = pin[`LHI_SV_CLKSRC];
  assign enStyle = pin[`LHI_SV_STYLE];
  assign parMode = pin[`LHI_SV_PAR];
  assign stbN = pin[`LHI_SV_STBN];
  assign rstN = pin[`LHI_SV_RSTN];

  // ***********************************
  // Next-state logic
  // ***********************************
  // Host port, oscillator and mode flags in one pass
  always_comb begin
    next_s = s;
    drive = 1'b0;
    next_s.wrStb = 1'b0;
    next_s.rdStb = 1'b0;
    // Edge history of strobes and serial clock
    // History bits follow the pins every cycle, whatever the mode
    next_s.wrWasLow = ~wrN;
    next_s.enWasHigh = rdN;
    next_s.sckWasLow = ~dBus[6];
    next_s.standby = ~stbN;
    next_s.inReset = ~rstN;
    if (!rstN) begin
      // Pin reset: drop everything in flight
      next_s.shift = 8'h00;
      next_s.bitCnt = 3'h0;
      next_s.dataOe = 8'h00;
    end else if (parMode) begin
      // Parallel port
      if (enStyle) begin
        // Enable style: read pin is E, write pin is direction
        drive = csOn & rdN & wrN;
        // Write qualifies on the falling edge of enable with direction low;
        // the registered history bit stands in for the edge itself
        if (csOn && s.enWasHigh && !rdN && !wrN) begin
          next_s.wrStb = 1'b1;
          next_s.wrIsData = rsel;
          next_s.wrByte = dBus;
        end
      end else begin
        // Strobe style
        drive = csOn & ~rdN;
        // Capture at the rising write strobe; the data still stands then
        // because the host holds it past the end of the strobe
        if (csOn && s.wrWasLow && wrN) begin
          next_s.wrStb = 1'b1;
          next_s.wrIsData = rsel;
          next_s.wrByte = dBus;
        end
      end
      next_s.dataOe = {8{drive}};
      next_s.dataOut = readData;
      // One pulse when a read cycle starts driving
      next_s.rdStb = drive & ~s.dataOe[0];
      // Leaving serial mode abandons any partial byte
      next_s.bitCnt = 3'h0;
    end else begin
      // Serial port: never drives the bus
      next_s.dataOe = 8'h00;
      if (!csOn) begin
        // Restart on deselect, so a frame cut short by the host never
        // shifts the next byte out of alignment
        next_s.bitCnt = 3'h0;
      end else if (s.sckWasLow && dBus[6]) begin
        next_s.shift = {s.shift[6:0], dBus[7]};
        if (s.bitCnt == 3'h7) begin
          // Eighth rising edge completes the byte
          next_s.wrStb = 1'b1;
          next_s.wrIsData = rsel;
          next_s.wrByte = {s.shift[6:0], dBus[7]};
          next_s.bitCnt = 3'h0;
        end else begin
          next_s.bitCnt = s.bitCnt + 3'h1;
        end
      end
    end
    // Internal oscillator runs only when selected and awake
    // Pin stays driven in standby, so a monitor sees a quiet low level
    // rather than a floating line
    next_s.clkOe = oscSel;
    if (oscSel && stbN && rstN) begin
      if (s.oscCnt == 8'(OSC_HALF - 1)) begin
        next_s.oscCnt = 8'h00;
        next_s.oscClk = ~s.oscClk;
      end else begin
        next_s.oscCnt = s.oscCnt + 8'h01;
      end
    end else begin
      // Oscillator stopped
      next_s.oscCnt = 8'h00;
      next_s.oscClk = 1'b0;
    end
    // Display clock from oscillator or from the pin
    next_s.dispClk = oscSel ? s.oscClk : clkPin;
  end

  // State register
  // Synchronous reset clears every field, the bus drive included
  always_ff @(posedge mclk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ***********************************
  // Outputs
  // ***********************************
  // Every output comes straight from the state register
  assign bus.devDataOut = s.dataOut;
  assign bus.devDataOe = s.dataOe;
  assign bus.devClkOut = s.oscClk;
  assign bus.devClkOe = s.clkOe;
  assign writeStrobe = s.wrStb;
  assign writeIsData = s.wrIsData;
  assign writeByte = s.wrByte;
  assign readStrobe = s.rdStb;
  assign deviceInReset = s.inReset;
  assign deviceStandby = s.standby;
  assign displayClock = s.dispClk;
endmodule : lhi_device

// *** lhi_host.sv ***
// Host controller end: drives the LCD driver's parallel or serial port
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "lhi_params.svh"
module lhi_host #(
  parameter int PHASE = `LHI_PHASE_CYCLES,
  parameter int SCK_HALF = `LHI_SCK_HALF_CYCLES,
  parameter int EXT_HALF = `LHI_EXT_CLK_HALF_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  lhi_bus_if.host bus,
  input wire logic cmdWrite,
  input wire logic cmdRead,
  input wire logic cmdIsData,
  input wire logic [7:0] cmdByte,
  input wire logic parallelReq,
  input wire logic enableStyleReq,
  input wire logic oscillatorReq,
  input wire logic resetReqN,
  input wire logic standbyReqN,
  output logic busy,
  output logic readValid,
  output logic [7:0] readByte
);
  // Registered state and its next value
  lhi_pkg::lhi_host_t s;
  lhi_pkg::lhi_host_t next_s;
  // Data bus after two flip-flops
  logic [7:0] busSync;
  // Last count of the current phase
  logic phaseEnd;
  logic halfEnd;

  lhi_sync #(.WIDTH(8)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .async(bus.dataBus),
    .synced(busSync)
  );

  assign phaseEnd = (s.cnt == 8'(PHASE - 1));
  assign halfEnd = (s.cnt == 8'(SCK_HALF - 1));

  // ***********************************
  // Sequencer
  // ***********************************
  always_comb begin
    next_s = s;
    next_s.rdValid = 1'b0;
    next_s.cnt = s.cnt + 8'h01;
    // Straps and control pins follow user requests
    next_s.rstN = resetReqN;
    next_s.stbN = standbyReqN;
    next_s.clkSrc = oscillatorReq;
    unique case (s.st)
      lhi_pkg::HIDLE: begin
        next_s.cnt = 8'h00;
        next_s.par = parallelReq;
        next_s.style = enableStyleReq;
        // Idle strobe levels per style
        next_s.rdN = ~s.style;
        next_s.wrN = 1'b1;
        next_s.csLowN = 1'b1;
        next_s.csHigh = 1'b0;
        next_s.dataOe = 8'h00;
        // Serial link carries writes only
        if (cmdWrite || (cmdRead && s.par)) begin
          next_s.st = lhi_pkg::HSETUP;
          next_s.busy = 1'b1;
          next_s.isRead = ~cmdWrite;
          next_s.rsel = cmdIsData;
          next_s.byteOut = cmdByte;
          next_s.csLowN = 1'b0;
          next_s.csHigh = 1'b1;
          next_s.wrN = ~(s.style & cmdWrite);
          next_s.dataOut = cmdByte;
          next_s.dataOe = s.par ? {8{cmdWrite}} : 8'hc0;
          if (!s.par) begin
            next_s.dataOut = 8'h00;
          end
        end
      end
      lhi_pkg::HSETUP: begin
        if (phaseEnd) begin
          next_s.cnt = 8'h00;
          next_s.bitIdx = 3'h7;
          if (s.par) begin
            next_s.st = lhi_pkg::HACT;
            if (s.style) begin
              next_s.rdN = 1'b1;
            end else begin
              next_s.rdN = ~s.isRead;
              next_s.wrN = s.isRead;
            end
          end else begin
            next_s.st = lhi_pkg::HSLOW;
          end
        end
      end
      lhi_pkg::HACT: begin
        if (phaseEnd) begin
          next_s.cnt = 8'h00;
          next_s.st = lhi_pkg::HHOLD;
          next_s.rdN = ~s.style;
          next_s.wrN = s.style ? s.wrN : 1'b1;
          if (s.isRead) begin
            next_s.rdValid = 1'b1;
            next_s.rdByte = busSync;
          end
        end
      end
      lhi_pkg::HSLOW: begin
        // Serial data set up while clock is low
        next_s.dataOut[6] = 1'b0;
        next_s.dataOut[7] = s.byteOut[s.bitIdx];
        if (halfEnd) begin
          next_s.cnt = 8'h00;
          next_s.st = lhi_pkg::HSHIGH;
          next_s.dataOut[6] = 1'b1;
        end
      end
      lhi_pkg::HSHIGH: begin
        if (halfEnd) begin
          next_s.cnt = 8'h00;
          next_s.dataOut[6] = 1'b0;
          next_s.bitIdx = s.bitIdx - 3'h1;
          next_s.st = (s.bitIdx == 3'h0) ? lhi_pkg::HEND : lhi_pkg::HSLOW;
        end
      end
      lhi_pkg::HHOLD, lhi_pkg::HEND: begin
        // Select and data stay valid past the last edge
        if (phaseEnd) begin
          next_s.cnt = 8'h00;
          next_s.st = lhi_pkg::HIDLE;
          next_s.busy = 1'b0;
          next_s.csLowN = 1'b1;
          next_s.csHigh = 1'b0;
          next_s.dataOe = 8'h00;
          next_s.wrN = 1'b1;
        end
      end
    endcase
    // External display clock when the oscillator is off
    next_s.extOe = ~s.clkSrc;
    if (s.extCnt == 8'(EXT_HALF - 1)) begin
      next_s.extCnt = 8'h00;
      next_s.extClk = ~s.extClk;
    end else begin
      next_s.extCnt = s.extCnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ***********************************
  // Outputs
  // ***********************************
  assign bus.resetN = s.rstN;
  assign bus.standbyN = s.stbN;
  assign bus.parallelSel = s.par;
  assign bus.busStyleSel = s.style;
  assign bus.clockSourceStrap = s.clkSrc;
  assign bus.chipSelectLowActiveN = s.csLowN;
  assign bus.chipSelectHighActive = s.csHigh;
  assign bus.registerSelect = s.rsel;
  assign bus.readStrobeN = s.rdN;
  assign bus.writeStrobeN = s.wrN;
  assign bus.hostDataOut = s.dataOut;
  assign bus.hostDataOe = s.dataOe;
  assign bus.hostClkOut = s.extClk;
  assign bus.hostClkOe = s.extOe;
  assign busy = s.busy;
  assign readValid = s.rdValid;
  assign readByte = s.rdByte;
endmodule : lhi_host

// *** lhi_link_props.sv ***
// Rule checker for the pins between host controller and LCD driver
`timescale 1ns/1ps
module lhi_link_props (
  input wire logic mclk,
  input wire logic srst,
  input wire logic resetN,
  input wire logic standbyN,
  input wire logic parallelSel,
  input wire logic busStyleSel,
  input wire logic clockSourceStrap,
  input wire logic chipSelectLowActiveN,
  input wire logic chipSelectHighActive,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic [7:0] hostDataOe,
  input wire logic [7:0] devDataOe,
  input wire logic devClkOut,
  input wire logic devClkOe
);
  // ***********************************
  // Helpers
  // ***********************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  logic csOn; // Both selects active
  logic [1:0] upCnt; // Cycles since reset release, saturating
  assign csOn = !chipSelectLowActiveN && chipSelectHighActive;
  // Count out the first edges after reset, when host pins still settle
  always_ff @(posedge mclk) begin
    if (srst) begin
      upCnt <= 2'h0;
    end else if (upCnt != 2'h3) begin
      upCnt <= upCnt + 2'h1;
    end
  end
  // ***********************************
  // Assertions
  // ***********************************
  serial_lines_idle_a: assert property ((!parallelSel)[*4] |-> devDataOe == 8'h00)
    else $error("device drives data lines in serial mode");
  deselect_release_a: assert property ((!csOn)[*4] |-> devDataOe == 8'h00)
    else $error("device drives bus while deselected");
  strobe_read_drive_a: assert property (
    (parallelSel && !busStyleSel && csOn && !readStrobeN)[*5] |-> devDataOe == 8'hff)
    else $error("no read drive under low read strobe");
  enable_read_drive_a: assert property (
    (parallelSel && busStyleSel && csOn && readStrobeN && writeStrobeN)[*5] |-> devDataOe == 8'hff)
    else $error("no read drive while enable high");
  write_dir_release_a: assert property ((busStyleSel && !writeStrobeN)[*5] |-> devDataOe == 8'h00)
    else $error("device drives bus with write direction");
  host_strobe_select_a: assert property (
    upCnt == 2'h3 && parallelSel && $past(parallelSel) && !busStyleSel
    && !$past(busStyleSel) && !(readStrobeN && writeStrobeN) |-> csOn)
    else $error("host strobe without chip selects");
  bus_contention_a: assert property (upCnt == 2'h3 |-> (hostDataOe & devDataOe) == 8'h00)
    else $error("both ends drive one data line");
  osc_monitor_drive_a: assert property ((clockSourceStrap && resetN && standbyN)[*5] |-> devClkOe)
    else $error("clock pin not driven with oscillator selected");
  ext_clock_input_a: assert property ((!clockSourceStrap)[*5] |-> !devClkOe)
    else $error("device drives clock pin in external mode");
  osc_running_a: assert property (
    (clockSourceStrap && resetN && standbyN)[*5] |-> ##[1:8] $changed(devClkOut))
    else $error("oscillator output not toggling");
  standby_clock_stop_a: assert property ((clockSourceStrap && !standbyN)[*5] |-> $stable(devClkOut))
    else $error("oscillator runs in standby");
  // Main scenarios reached
  cover property (!parallelSel && csOn);
  cover property (devDataOe == 8'hff);
  cover property (devClkOe && $rose(devClkOut));
endmodule : lhi_link_props

// *** lhi_params.svh ***
// Timing counts and bit positions for the LCD host interface
`ifndef LHI_PARAMS_SVH
`define LHI_PARAMS_SVH
// ***********************************
// Clock and link timing
// ***********************************
`define LHI_MCLK_PERIOD_NS 25
`define LHI_SCK_PERIOD_NS 200
`define LHI_SCK_HALF_CYCLES (`LHI_SCK_PERIOD_NS / (2 * `LHI_MCLK_PERIOD_NS))
`define LHI_PHASE_NS 200
`define LHI_PHASE_CYCLES (`LHI_PHASE_NS / `LHI_MCLK_PERIOD_NS)
`define LHI_OSC_HALF_CYCLES 4
`define LHI_EXT_CLK_HALF_CYCLES 5
// ***********************************
// Device input sync vector layout
// ***********************************
`define LHI_SV_WIDTH 19
`define LHI_SV_DATA 0
`define LHI_SV_CLKPIN 8
`define LHI_SV_WRN 9
`define LHI_SV_RDN 10
`define LHI_SV_RSEL 11
`define LHI_SV_CSH 12
`define LHI_SV_CSLN 13
`define LHI_SV_CLKSRC 14
`define LHI_SV_STYLE 15
`define LHI_SV_PAR 16
`define LHI_SV_STBN 17
`define LHI_SV_RSTN 18
`endif

// *** lhi_pkg.sv ***
// State types for the LCD host interface ends
package lhi_pkg;
  // Device end state
  typedef struct packed {
    logic inReset;
    logic standby;
    logic wrWasLow;
    logic enWasHigh;
    logic sckWasLow;
    logic [7:0] shift;
    logic [2:0] bitCnt;
    logic [7:0] dataOut;
    logic [7:0] dataOe;
    logic wrStb;
    logic wrIsData;
    logic [7:0] wrByte;
    logic rdStb;
    logic [7:0] oscCnt;
    logic oscClk;
    logic clkOe;
    logic dispClk;
  } lhi_dev_t;
  // Host sequencer states
  typedef enum logic [2:0] {HIDLE, HSETUP, HACT, HHOLD, HSLOW, HSHIGH, HEND} lhi_hstate_t;
  // Host end state
  typedef struct packed {
    lhi_hstate_t st;
    logic [7:0] cnt;
    logic [2:0] bitIdx;
    logic isRead;
    logic [7:0] byteOut;
    logic csLowN;
    logic csHigh;
    logic rsel;
    logic rdN;
    logic wrN;
    logic [7:0] dataOut;
    logic [7:0] dataOe;
    logic busy;
    logic rdValid;
    logic [7:0] rdByte;
    logic [7:0] extCnt;
    logic extClk;
    logic extOe;
    logic rstN;
    logic stbN;
    logic par;
    logic style;
    logic clkSrc;
  } lhi_host_t;
endpackage : lhi_pkg

// *** lhi_sync.sv ***
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module lhi_sync #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  // Both stages in one state word
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } lhi_sync_t;
  lhi_sync_t s;
  lhi_sync_t next_s;
  // ***********************************
  // Stage shift
  // ***********************************
  // First stage feeds only the second
  always_comb begin
    next_s = s;
    next_s.meta = async;
    next_s.stable = s.meta;
  end
  // Register both stages
  always_ff @(posedge mclk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign synced = s.stable;
endmodule : lhi_sync

// *** lhi_tb_top.sv ***
// Self-checking bench joining host controller and LCD driver ends
`timescale 1ns/1ps
module lhi_tb_top;
  // ***********************************
  // Stimulus and observed signals
  // ***********************************
  logic mclk, srst, cmdWrite, cmdRead, cmdIsData, parallelReq, enableStyleReq;
  logic oscillatorReq, resetReqN, standbyReqN, busy, readValid, writeStrobe, writeIsData;
  logic readStrobe, deviceInReset, deviceStandby, displayClock, csOn;
  logic [7:0] cmdByte, readByte, readData, writeByte;
  // Recorder state, written only by the recorder process
  logic wrIsData = 1'b0;
  logic sckLast = 1'b0;
  logic lowIdle = 1'b1;
  logic [7:0] wrByte = 8'h00;
  logic [7:0] rdGot = 8'h00;
  logic [7:0] serShift = 8'h00;
  int wrCnt = 0;
  int rdCnt = 0;
  int rsCnt = 0;
  int n_fail, comparisons;
  lhi_bus_if bus ();
  lhi_host u_lhi_host (.mclk(mclk), .srst(srst), .bus(bus.host), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
    .cmdIsData(cmdIsData), .cmdByte(cmdByte), .parallelReq(parallelReq), .enableStyleReq(enableStyleReq),
    .oscillatorReq(oscillatorReq), .resetReqN(resetReqN), .standbyReqN(standbyReqN), .busy(busy),
    .readValid(readValid), .readByte(readByte));
  lhi_device u_lhi_device (.mclk(mclk), .srst(srst), .bus(bus.dev), .readData(readData),
    .writeStrobe(writeStrobe), .writeIsData(writeIsData), .writeByte(writeByte), .readStrobe(readStrobe),
    .deviceInReset(deviceInReset), .deviceStandby(deviceStandby), .displayClock(displayClock));
  lhi_link_props u_lhi_link_props (.mclk(mclk), .srst(srst), .resetN(bus.resetN), .standbyN(bus.standbyN),
    .parallelSel(bus.parallelSel), .busStyleSel(bus.busStyleSel), .clockSourceStrap(bus.clockSourceStrap),
    .chipSelectLowActiveN(bus.chipSelectLowActiveN), .chipSelectHighActive(bus.chipSelectHighActive),
    .readStrobeN(bus.readStrobeN), .writeStrobeN(bus.writeStrobeN), .hostDataOe(bus.hostDataOe),
    .devDataOe(bus.devDataOe), .devClkOut(bus.devClkOut), .devClkOe(bus.devClkOe));
  assign csOn = !bus.chipSelectLowActiveN && bus.chipSelectHighActive;
  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Record delivered bytes, reads and serial wire bits
  always @(posedge mclk) begin
    sckLast <= bus.dataBus[6];
    if (writeStrobe) begin
      wrCnt <= wrCnt + 1;
      wrByte <= writeByte;
      wrIsData <= writeIsData;
    end
    if (readValid) begin
      rdCnt <= rdCnt + 1;
      rdGot <= readByte;
    end
    if (readStrobe) begin
      rsCnt <= rsCnt + 1;
    end
    if (!bus.parallelSel && csOn && bus.dataBus[6] && !sckLast) begin
      serShift <= {serShift[6:0], bus.dataBus[7]};
      lowIdle <= lowIdle & (bus.dataBus[5:0] == 6'h3f);
    end
  end
  // ***********************************
  // Shared tasks
  // ***********************************
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chk1(input string what, input logic got);
    comparisons++;
    if (got !== 1'b1) begin
      n_fail++;
      $display("mismatch %s expected 1 seen %b", what, got);
    end
  endtask : chk1
  task automatic print_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // One host command, then bounded wait for the transfer to finish
  task automatic hostCmd(input logic rd, input logic isData, input logic [7:0] b);
    int i;
    @(posedge mclk);
    cmdWrite <= !rd;
    cmdRead <= rd;
    cmdIsData <= isData;
    cmdByte <= b;
    @(posedge mclk);
    cmdWrite <= 1'b0;
    cmdRead <= 1'b0;
    @(posedge mclk);
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge mclk);
    if (i == 400) begin
      n_fail++;
      print_verdict();
    end
    repeat (8) @(posedge mclk);
  endtask : hostCmd
  task automatic setMode(input logic par, input logic sty, input logic osc);
    @(posedge mclk);
    parallelReq <= par;
    enableStyleReq <= sty;
    oscillatorReq <= osc;
    repeat (12) @(posedge mclk);
  endtask : setMode
  // Number write, data write and read-back on the parallel bus
  task automatic xferCheck(input logic [7:0] b);
    int n;
    int m;
    m = rsCnt;
    n = wrCnt;
    hostCmd(1'b0, 1'b0, b);
    chk8("number byte", b, wrByte);
    chk1("number flag", wrIsData === 1'b0);
    hostCmd(1'b0, 1'b1, ~b);
    chk8("data byte", ~b, wrByte);
    chk1("data flag", wrIsData === 1'b1);
    chk1("write count", wrCnt == n + 2);
    readData <= b ^ 8'h5a;
    n = rdCnt;
    hostCmd(1'b1, 1'b1, 8'h00);
    chk8("read byte", b ^ 8'h5a, rdGot);
    chk1("read count", rdCnt == n + 1);
    chk1("read strobe count", rsCnt == m + 1);
  endtask : xferCheck
  task automatic countTog(output int p, output int d);
    logic lp, ld;
    p = 0;
    d = 0;
    for (int i = 0; i < 80; i++) begin
      lp = bus.oscillatorMonitorPin;
      ld = displayClock;
      @(posedge mclk);
      p += (lp !== bus.oscillatorMonitorPin);
      d += (ld !== displayClock);
    end
  endtask : countTog
  // ***********************************
  // Scenarios
  // ***********************************
  task automatic testStrobe();
    setMode(1'b1, 1'b0, 1'b1);
    xferCheck(8'h3c);
    $display("strobe style done");
  endtask : testStrobe
  task automatic testEnable();
    setMode(1'b1, 1'b1, 1'b1);
    xferCheck(8'h81);
    $display("enable style done");
  endtask : testEnable
  task automatic testSerial();
    int n;
    setMode(1'b0, 1'b0, 1'b1);
    hostCmd(1'b0, 1'b1, 8'h96);
    chk8("serial wire", 8'h96, serShift);
    chk8("serial byte", 8'h96, wrByte);
    chk1("serial data flag", wrIsData === 1'b1);
    hostCmd(1'b0, 1'b0, 8'h01);
    chk8("second serial byte", 8'h01, wrByte);
    chk1("serial number flag", wrIsData === 1'b0);
    chk1("low lines undriven", lowIdle);
    n = rdCnt + wrCnt;
    hostCmd(1'b1, 1'b1, 8'h00);
    chk1("serial read refused", rdCnt + wrCnt == n);
    $display("serial done");
  endtask : testSerial
  task automatic testClock();
    int p, d;
    setMode(1'b1, 1'b0, 1'b1);
    countTog(p, d);
    chk1("oscillator pin toggles", p >= 19 && p <= 21);
    setMode(1'b1, 1'b0, 1'b0);
    countTog(p, d);
    chk1("external pin toggles", p >= 15 && p <= 17);
    chk1("display clock toggles", d >= 15 && d <= 17);
    $display("clock source done");
  endtask : testClock
  task automatic testStandby();
    int p, d;
    setMode(1'b1, 1'b0, 1'b1);
    standbyReqN <= 1'b0;
    repeat (8) @(posedge mclk);
    chk1("standby entered", deviceStandby);
    countTog(p, d);
    chk1("oscillator stopped", p == 0);
    standbyReqN <= 1'b1;
    resetReqN <= 1'b0;
    repeat (8) @(posedge mclk);
    chk1("pin reset entered", deviceInReset);
    resetReqN <= 1'b1;
    repeat (8) @(posedge mclk);
    chk1("pin reset left", deviceInReset === 1'b0);
    hostCmd(1'b0, 1'b1, 8'h7e);
    chk8("write after reset", 8'h7e, wrByte);
    $display("standby and reset done");
  endtask : testStandby
  // Main sequence
  initial begin
    {srst, resetReqN, standbyReqN, parallelReq, oscillatorReq} = 5'h1f;
    {cmdWrite, cmdRead, cmdIsData, enableStyleReq} = 4'h0;
    {cmdByte, readData} = 16'h0000;
    {n_fail, comparisons} = '0;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    testStrobe();
    testEnable();
    testSerial();
    testClock();
    testStandby();
    print_verdict();
  end
endmodule : lhi_tb_top
